// *** inc/lcc_pkg.sv ***
// Constants of the loop controller configuration block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package lcc_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0]  IDX_MAINS      = 8'h51;
  localparam logic [7:0]  IDX_SMP        = 8'h52;
  localparam logic [7:0]  IDX_MODE_A     = 8'h53;
  localparam logic [7:0]  IDX_MODE_B     = 8'h54;
  localparam logic [7:0]  IDX_OPE        = 8'h60;
  localparam logic [7:0]  IDX_ENABLE     = 8'h61;
  localparam logic [7:0]  IDX_STATUS     = 8'h62;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic        MAINS_RST      = 1'b0;
  localparam logic        SMP_RST        = 1'b1;
  localparam logic        SMP_SHORT      = 1'b0;
  localparam logic [2:0]  MODE_RST       = 3'h0;
  localparam logic [2:0]  MODE_SINGLE    = 3'h0;
  localparam logic [2:0]  MODE_CHANGE    = 3'h1;
  localparam logic [2:0]  MODE_CASCADE   = 3'h2;
  localparam logic [2:0]  MODE_ODD_OFF   = 3'h3;
  localparam logic [2:0]  MODE_BOTH_OFF  = 3'h4;
  localparam logic [15:0] OPE_RST        = 16'h0000;
  localparam logic [15:0] OPE_APPLY      = 16'h0000;
  localparam logic [15:0] OPE_INIT_ALL   = 16'h0001;
  localparam int          ENABLE_GO_BIT  = 0;
  // ****************************************
  // Status register fields
  // ****************************************
  localparam int          ST_MAINS_BIT   = 0;
  localparam int          ST_SMP_BIT     = 1;
  localparam int          ST_LOCK_BIT    = 2;
  localparam int          ST_MODE_A_LSB  = 4;
  localparam int          ST_MODE_B_LSB  = 8;
endpackage

// *** core/lcc_top.sv ***
// Module-wide configuration registers of a four-loop control module.
// Assumes one 40 MHz clock, an Avalon-MM master and two asynchronous switch pins.
// How it works
// - Enable with operand set to initialize-all restores every default.
// - Written controller values stay staged until the enable command.
// - An applied controller change pulses the default-reset output.
// - Mode moves among codes 0, 3 and 4 only do not pulse defaults.
// - With the hardware switch selecting mains, software mains writes are ignored.
// - Sampling register: 0 is 100 ms, 1 is 200 ms, default 1.
// - Short period lets only loops one and two control; long allows four.
// - Output function of loops three and four stays with short period.
// - Two mode registers, loops 1-2 and 3-4, accept 0 to 4, default 0.
// - Code 0 runs both loops as independent single loops.
// - Code 1 is changeover: odd loop low input, even loop high input.
// - In changeover odd loop gives input only; even loop parameters control.
// - In cascade only the even loop parameter set is used.
// - Code 3 disables the odd loop; even loop runs single.
// - Code 4 disables both loops of the pair.
`timescale 1ns/100ps
`default_nettype none
module lcc_top (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Avalon-MM slave
  input  wire logic [9:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Hardware mains switch pins
  input  wire logic        MAINS_SW_EN_I,
  input  wire logic        MAINS_SW_SEL_I,
  // Effective configuration
  output logic             MAINS_60HZ_O,
  output logic             SMP_LONG_O,
  output logic [3:0]       LOOP_CONTROL_O,
  output logic [3:0]       LOOP_INPUT_O,
  output logic [3:0]       LOOP_PARAMS_O,
  output logic [3:0]       LOOP_OUTPUT_O,
  output logic [1:0]       PAIR_CHANGE_O,
  output logic [1:0]       PAIR_CASCADE_O,
  output logic             PARAM_DEFAULT_O
);

  // ****************************************
  // Switch synchronisers
  // ****************************************
  logic [1:0] sw_en_q;
  logic [1:0] sw_sel_q;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sw_en_q  <= 2'h0;
      sw_sel_q <= 2'h0;
    end else begin
      sw_en_q  <= {sw_en_q[0], MAINS_SW_EN_I};
      sw_sel_q <= {sw_sel_q[0], MAINS_SW_SEL_I};
    end
  end

  logic sw_lock;
  assign sw_lock = sw_en_q[1];

  // ****************************************
  // Bus handshake
  // ****************************************
  logic       ack_q;
  logic       req;
  logic       wr_acc;
  logic [7:0] idx;
  logic       idx_ok;

  assign req               = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~ack_q;
  assign wr_acc            = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0] & idx_ok;
  assign idx               = AVS_ADDRESS_I[9:2];
  assign idx_ok            = (AVS_ADDRESS_I[1:0] == 2'h0);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ****************************************
  // Staged and active registers
  // ****************************************
  logic        st_mains_q;
  logic        st_smp_q;
  logic [2:0]  st_mode_a_q;
  logic [2:0]  st_mode_b_q;
  logic [15:0] ope_q;
  logic        act_mains_q;
  logic        act_smp_q;
  logic [2:0]  act_mode_a_q;
  logic [2:0]  act_mode_b_q;
  logic        go_q;
  logic [2:0]  wmode;
  logic        init_go;
  logic        apply_go;

  assign wmode    = AVS_WRITEDATA_I[2:0];
  assign init_go  = go_q & (ope_q == lcc_pkg::OPE_INIT_ALL);
  assign apply_go = go_q & (ope_q != lcc_pkg::OPE_INIT_ALL);

  function automatic logic mode_ok(input logic [31:0] d);
    mode_ok = (d[31:3] == 29'h0) && (d[2:0] <= lcc_pkg::MODE_BOTH_OFF);
  endfunction

  function automatic logic soft_mode(input logic [2:0] m);
    soft_mode = (m == lcc_pkg::MODE_SINGLE) || (m == lcc_pkg::MODE_ODD_OFF) ||
                (m == lcc_pkg::MODE_BOTH_OFF);
  endfunction

  // Enable command, taken one cycle after the write
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_acc & (idx == lcc_pkg::IDX_ENABLE) &
              AVS_WRITEDATA_I[lcc_pkg::ENABLE_GO_BIT];
    end
  end

  // Staged values written by software
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_mains_q  <= lcc_pkg::MAINS_RST;
      st_smp_q    <= lcc_pkg::SMP_RST;
      st_mode_a_q <= lcc_pkg::MODE_RST;
      st_mode_b_q <= lcc_pkg::MODE_RST;
      ope_q       <= lcc_pkg::OPE_RST;
    end else if (init_go) begin
      st_mains_q  <= lcc_pkg::MAINS_RST;
      st_smp_q    <= lcc_pkg::SMP_RST;
      st_mode_a_q <= lcc_pkg::MODE_RST;
      st_mode_b_q <= lcc_pkg::MODE_RST;
      ope_q       <= lcc_pkg::OPE_RST;
    end else if (wr_acc) begin
      case (idx)
        lcc_pkg::IDX_MAINS: begin
          if (!sw_lock && AVS_WRITEDATA_I[31:1] == 31'h0) begin
            st_mains_q <= AVS_WRITEDATA_I[0];
          end
        end
        lcc_pkg::IDX_SMP: begin
          if (AVS_WRITEDATA_I[31:1] == 31'h0) begin
            st_smp_q <= AVS_WRITEDATA_I[0];
          end
        end
        lcc_pkg::IDX_MODE_A: begin
          if (mode_ok(AVS_WRITEDATA_I)) begin
            st_mode_a_q <= wmode;
          end
        end
        lcc_pkg::IDX_MODE_B: begin
          if (mode_ok(AVS_WRITEDATA_I)) begin
            st_mode_b_q <= wmode;
          end
        end
        lcc_pkg::IDX_OPE: begin
          ope_q <= AVS_WRITEDATA_I[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Active values only change on the enable command
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      act_mains_q  <= lcc_pkg::MAINS_RST;
      act_smp_q    <= lcc_pkg::SMP_RST;
      act_mode_a_q <= lcc_pkg::MODE_RST;
      act_mode_b_q <= lcc_pkg::MODE_RST;
    end else if (init_go) begin
      act_mains_q  <= lcc_pkg::MAINS_RST;
      act_smp_q    <= lcc_pkg::SMP_RST;
      act_mode_a_q <= lcc_pkg::MODE_RST;
      act_mode_b_q <= lcc_pkg::MODE_RST;
    end else if (apply_go) begin
      act_mains_q  <= st_mains_q;
      act_smp_q    <= st_smp_q;
      act_mode_a_q <= st_mode_a_q;
      act_mode_b_q <= st_mode_b_q;
    end
  end

  // ****************************************
  // Default-reset request
  // ****************************************
  logic soft_a;
  logic soft_b;
  logic need_default;

  assign soft_a = (st_mode_a_q == act_mode_a_q) ||
                  (soft_mode(st_mode_a_q) && soft_mode(act_mode_a_q));
  assign soft_b = (st_mode_b_q == act_mode_b_q) ||
                  (soft_mode(st_mode_b_q) && soft_mode(act_mode_b_q));
  assign need_default = (st_mains_q != act_mains_q) || (st_smp_q != act_smp_q) ||
                        !soft_a || !soft_b;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PARAM_DEFAULT_O <= 1'b0;
    end else begin
      PARAM_DEFAULT_O <= init_go | (apply_go & need_default);
    end
  end

  // ****************************************
  // Loop roles per pair
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MAINS_60HZ_O <= lcc_pkg::MAINS_RST;
      SMP_LONG_O   <= lcc_pkg::SMP_RST;
    end else begin
      MAINS_60HZ_O <= sw_lock ? sw_sel_q[1] : act_mains_q;
      SMP_LONG_O   <= act_smp_q;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic [2:0] m;
    logic       usable;
    assign m      = (p == 0) ? act_mode_a_q : act_mode_b_q;
    assign usable = (p == 0) || (act_smp_q != lcc_pkg::SMP_SHORT);
    // Roles as {control, input, params, output}, each {even, odd}
    logic [7:0] role;
    always_comb begin
      role = 8'h0;
      case (m)
        lcc_pkg::MODE_SINGLE:  role = {{6{usable}}, 2'h3};
        lcc_pkg::MODE_CHANGE:  role = {usable, 1'b0, {3{usable}}, 3'h2};
        lcc_pkg::MODE_CASCADE: role = {{5{usable}}, 3'h2};
        lcc_pkg::MODE_ODD_OFF: role = {{3{usable, 1'b0}}, 2'h2};
        default:               role = 8'h0;
      endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
        LOOP_CONTROL_O[2*p+1:2*p] <= 2'h0;
        LOOP_INPUT_O[2*p+1:2*p]   <= 2'h0;
        LOOP_PARAMS_O[2*p+1:2*p]  <= 2'h0;
        LOOP_OUTPUT_O[2*p+1:2*p]  <= 2'h0;
        PAIR_CHANGE_O[p]          <= 1'b0;
        PAIR_CASCADE_O[p]         <= 1'b0;
      end else begin
        LOOP_CONTROL_O[2*p+1:2*p] <= role[7:6];
        LOOP_INPUT_O[2*p+1:2*p]   <= role[5:4];
        LOOP_PARAMS_O[2*p+1:2*p]  <= role[3:2];
        LOOP_OUTPUT_O[2*p+1:2*p]  <= role[1:0];
        PAIR_CHANGE_O[p]  <= (m == lcc_pkg::MODE_CHANGE);
        PAIR_CASCADE_O[p] <= (m == lcc_pkg::MODE_CASCADE);
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0;
    if (idx_ok) begin
      case (idx)
        lcc_pkg::IDX_MAINS:  rd_d[0]   = sw_lock ? sw_sel_q[1] : st_mains_q;
        lcc_pkg::IDX_SMP:    rd_d[0]   = st_smp_q;
        lcc_pkg::IDX_MODE_A: rd_d[2:0] = st_mode_a_q;
        lcc_pkg::IDX_MODE_B: rd_d[2:0] = st_mode_b_q;
        lcc_pkg::IDX_OPE:    rd_d[15:0] = ope_q;
        lcc_pkg::IDX_STATUS: begin
          rd_d[lcc_pkg::ST_MAINS_BIT]                          = MAINS_60HZ_O;
          rd_d[lcc_pkg::ST_SMP_BIT]                            = act_smp_q;
          rd_d[lcc_pkg::ST_LOCK_BIT]                           = sw_lock;
          rd_d[lcc_pkg::ST_MODE_A_LSB+2:lcc_pkg::ST_MODE_A_LSB] = act_mode_a_q;
          rd_d[lcc_pkg::ST_MODE_B_LSB+2:lcc_pkg::ST_MODE_B_LSB] = act_mode_b_q;
        end
        default:             rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      AVS_READDATA_O <= 32'h0;
    end else if (AVS_READ_I && !ack_q) begin
      AVS_READDATA_O <= rd_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_staged_only;
    !go_q |=> $stable(act_mode_a_q) && $stable(act_mode_b_q) && $stable(act_smp_q);
  endproperty
  a_staged_only: assert property (p_staged_only) else $error("active changed without enable");
  property p_default_on_change;
    apply_go && (st_smp_q != act_smp_q) |=> PARAM_DEFAULT_O ##1 !PARAM_DEFAULT_O;
  endproperty
  a_default_on_change: assert property (p_default_on_change) else $error("no default pulse");
  property p_soft_mode;
    apply_go && (st_smp_q == act_smp_q) && (st_mains_q == act_mains_q) &&
    soft_mode(st_mode_a_q) && soft_mode(act_mode_a_q) &&
    (st_mode_b_q == act_mode_b_q) |=> !PARAM_DEFAULT_O;
  endproperty
  a_soft_mode: assert property (p_soft_mode) else $error("default pulse on soft mode move");
  property p_init_all;
    init_go |=> PARAM_DEFAULT_O && act_smp_q == lcc_pkg::SMP_RST &&
                act_mode_a_q == lcc_pkg::MODE_RST && act_mode_b_q == lcc_pkg::MODE_RST;
  endproperty
  a_init_all: assert property (p_init_all) else $error("initialize-all incomplete");
  property p_switch_lock;
    sw_lock && AVS_WRITE_I && idx == lcc_pkg::IDX_MAINS && !init_go |=> $stable(st_mains_q);
  endproperty
  a_switch_lock: assert property (p_switch_lock) else $error("mains write while locked");
  property p_short_period;
    act_smp_q == lcc_pkg::SMP_SHORT |=> LOOP_CONTROL_O[3:2] == 2'h0;
  endproperty
  a_short_period: assert property (p_short_period) else $error("loops 3-4 control on short");
  property p_output_kept;
    act_smp_q == lcc_pkg::SMP_SHORT && act_mode_b_q == lcc_pkg::MODE_SINGLE
      |=> LOOP_OUTPUT_O[3:2] == 2'h3;
  endproperty
  a_output_kept: assert property (p_output_kept) else $error("outputs lost on short");
  property p_odd_off;
    act_mode_a_q == lcc_pkg::MODE_ODD_OFF |=> LOOP_CONTROL_O[1:0] == 2'h2;
  endproperty
  a_odd_off: assert property (p_odd_off) else $error("mode 3 roles wrong");
  property p_both_off;
    act_mode_b_q == lcc_pkg::MODE_BOTH_OFF |=> LOOP_INPUT_O[3:2] == 2'h0 &&
                                               LOOP_CONTROL_O[3:2] == 2'h0;
  endproperty
  a_both_off: assert property (p_both_off) else $error("mode 4 loops active");
  property p_even_params;
    (act_mode_a_q == lcc_pkg::MODE_CHANGE) || (act_mode_a_q == lcc_pkg::MODE_CASCADE)
      |=> LOOP_PARAMS_O[1:0] == 2'h2 && LOOP_INPUT_O[0];
  endproperty
  a_even_params: assert property (p_even_params) else $error("odd params used");
  property p_bus_answer;
    $rose(req) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");
  c_init:    cover property (init_go ##1 PARAM_DEFAULT_O);
  c_soft:    cover property (apply_go && st_mode_a_q == lcc_pkg::MODE_BOTH_OFF &&
                             act_mode_a_q == lcc_pkg::MODE_SINGLE ##1 !PARAM_DEFAULT_O);
  c_cascade: cover property (PAIR_CASCADE_O[1] && SMP_LONG_O);

endmodule // lcc_top
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the loop controller configuration block.
// Assumes lcc_pkg is compiled first and the block answers with one wait state.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        clk     = 1'b0;
  logic        rst_b   = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read    = 1'b0;
  logic        write   = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  be      = 4'h0;
  logic        sw_en   = 1'b0;
  logic        sw_sel  = 1'b0;
  logic [31:0] rdata;
  logic        waitreq, mains_60, smp_long, par_def;
  logic [3:0]  loop_ctl, loop_in, loop_par, loop_out;
  logic [1:0]  pair_chg, pair_cas;
  logic [31:0] pulses  = 32'h0;
  int          bad_count = 0;
  int          checks    = 0;

  always #12.5 clk = ~clk;

  lcc_top lcc_top_inst (
    .CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(address), .AVS_READ_I(read),
    .AVS_WRITE_I(write), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .MAINS_SW_EN_I(sw_en),
    .MAINS_SW_SEL_I(sw_sel), .MAINS_60HZ_O(mains_60), .SMP_LONG_O(smp_long),
    .LOOP_CONTROL_O(loop_ctl), .LOOP_INPUT_O(loop_in), .LOOP_PARAMS_O(loop_par),
    .LOOP_OUTPUT_O(loop_out), .PAIR_CHANGE_O(pair_chg), .PAIR_CASCADE_O(pair_cas),
    .PARAM_DEFAULT_O(par_def)
  );

  // Counts default-reset pulses
  always @(posedge clk) begin
    if (par_def === 1'b1) pulses <= pulses + 32'h1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] ben, output logic [31:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    wdata   <= d;
    be      <= ben;
    write   <= wr;
    read    <= ~wr;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 4'hf, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, 4'hf, q);
    check(q, exp);
  endtask

  // Enable command, then expect the given number of default pulses
  task automatic apply(input logic [31:0] exp_pulses);
    pulses <= 32'h0;
    wr(lcc_pkg::IDX_ENABLE, 32'h1);
    repeat (4) @(posedge clk);
    check(pulses, exp_pulses);
  endtask

  function automatic logic [5:0] pair_exp(input int code);
    // {control, input, params} as {even, odd} pairs
    case (code)
      0:       return 6'b11_11_11;
      1:       return 6'b10_11_10;
      2:       return 6'b11_11_10;
      3:       return 6'b10_10_10;
      default: return 6'b00_00_00;
    endcase
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(lcc_pkg::IDX_MAINS, 32'h0);
    rd_chk(lcc_pkg::IDX_SMP, 32'h1);
    rd_chk(lcc_pkg::IDX_MODE_A, 32'h0);
    rd_chk(lcc_pkg::IDX_MODE_B, 32'h0);
    rd_chk(8'h70, 32'h0);
    check({31'h0, smp_long}, 32'h1);
    check({28'h0, loop_ctl}, 32'hf);
  endtask

  // Each code on each pair, with the default pulse only outside 0, 3 and 4
  task automatic t_modes();
    int seq [7] = '{3, 4, 0, 1, 2, 0, 4};
    int prev;
    logic [5:0] e;
    logic [3:0] ctl_exp;
    logic [7:0] idx;
    for (int p = 0; p < 2; p++) begin
      idx  = (p == 0) ? lcc_pkg::IDX_MODE_A : lcc_pkg::IDX_MODE_B;
      prev = 0;
      for (int i = 0; i < 7; i++) begin
        e = pair_exp(prev);
        ctl_exp = (p == 0) ? {2'h3, e[5:4]} : {e[5:4], 2'h3};
        wr(idx, seq[i]);
        repeat (3) @(posedge clk);
        check({28'h0, loop_ctl}, {28'h0, ctl_exp});
        rd_chk(idx, seq[i]);
        apply((seq[i] == 1 || seq[i] == 2 || prev == 1 || prev == 2) ? 32'h1 : 32'h0);
        e = pair_exp(seq[i]);
        check({30'h0, loop_ctl[2*p +: 2]}, {30'h0, e[5:4]});
        check({30'h0, loop_in[2*p +: 2]}, {30'h0, e[3:2]});
        check({30'h0, loop_par[2*p +: 2]}, {30'h0, e[1:0]});
        check({31'h0, pair_chg[p]}, (seq[i] == 1) ? 32'h1 : 32'h0);
        check({31'h0, pair_cas[p]}, (seq[i] == 2) ? 32'h1 : 32'h0);
        ctl_exp = (p == 0) ? {2'h3, e[5:4]} : {e[5:4], 2'h3};
        check({28'h0, loop_ctl}, {28'h0, ctl_exp});
        prev = seq[i];
      end
      wr(idx, 32'h0);
      apply(32'h0);
    end
  endtask

  task automatic t_refused();
    logic [31:0] q;
    wr(lcc_pkg::IDX_MODE_A, 32'h5);
    rd_chk(lcc_pkg::IDX_MODE_A, 32'h0);
    bus(1'b1, lcc_pkg::IDX_MODE_A, 32'h2, 4'he, q);
    rd_chk(lcc_pkg::IDX_MODE_A, 32'h0);
  endtask

  task automatic t_sampling();
    wr(lcc_pkg::IDX_SMP, 32'h0);
    apply(32'h1);
    check({31'h0, smp_long}, 32'h0);
    check({28'h0, loop_ctl}, 32'h3);
    check({28'h0, loop_out}, 32'hf);
    wr(lcc_pkg::IDX_SMP, 32'h1);
    apply(32'h1);
    check({28'h0, loop_ctl}, 32'hf);
  endtask

  task automatic t_mains();
    wr(lcc_pkg::IDX_MAINS, 32'h1);
    apply(32'h1);
    check({31'h0, mains_60}, 32'h1);
    @(posedge clk);
    sw_en <= 1'b1;
    repeat (5) @(posedge clk);
    check({31'h0, mains_60}, 32'h0);
    rd_chk(lcc_pkg::IDX_MAINS, 32'h0);
    wr(lcc_pkg::IDX_MAINS, 32'h0);
    sw_sel <= 1'b1;
    repeat (5) @(posedge clk);
    check({31'h0, mains_60}, 32'h1);
    rd_chk(lcc_pkg::IDX_STATUS, 32'h7);
    sw_en  <= 1'b0;
    sw_sel <= 1'b0;
    repeat (5) @(posedge clk);
    rd_chk(lcc_pkg::IDX_MAINS, 32'h1);
    check({31'h0, mains_60}, 32'h1);
  endtask

  task automatic t_init_all();
    wr(lcc_pkg::IDX_SMP, 32'h0);
    wr(lcc_pkg::IDX_MODE_B, 32'h2);
    apply(32'h1);
    rd_chk(lcc_pkg::IDX_STATUS, 32'h201);
    wr(lcc_pkg::IDX_OPE, {16'h0, lcc_pkg::OPE_INIT_ALL});
    apply(32'h1);
    rd_chk(lcc_pkg::IDX_MAINS, 32'h0);
    rd_chk(lcc_pkg::IDX_SMP, 32'h1);
    rd_chk(lcc_pkg::IDX_MODE_B, 32'h0);
    rd_chk(lcc_pkg::IDX_OPE, 32'h0);
    check({28'h0, loop_ctl}, 32'hf);
    check({30'h0, pair_cas}, 32'h0);
    check({31'h0, mains_60}, 32'h0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_modes();
    t_refused();
    t_sampling();
    t_mains();
    t_init_all();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
